// ### inc/sbst_pkg.sv
/*
 Constants, state codes and cell layout of the SRAM boundary-scan test port.
 Assumes one 3-bit instruction register and a 107-cell boundary register.
*/
package sbst_pkg;
	// ------------------------------------------------------------
	// Instruction register
	// ------------------------------------------------------------
	localparam int unsigned SBST_IR_W       = 3;
	localparam logic [2:0]  SBST_I_EXTEST   = 3'h0; // Drive update data
	localparam logic [2:0]  SBST_I_IDCODE   = 3'h1; // Identification, reset default
	localparam logic [2:0]  SBST_I_SAMPZ    = 3'h2; // Sample with pins floated
	localparam logic [2:0]  SBST_I_SAMPLE   = 3'h4; // Sample / preload
	localparam logic [2:0]  SBST_I_BYPASS   = 3'h7; // One-bit path
	localparam logic [2:0]  SBST_IR_CAPTURE = 3'h1; // Fixed pattern at capture-IR

	// ------------------------------------------------------------
	// Data registers
	// ------------------------------------------------------------
	localparam int unsigned SBST_ID_W     = 32;  // Identification register
	localparam int unsigned SBST_BSR_LEN  = 107; // Boundary register cells
	localparam int unsigned SBST_CTL_BIT  = 106; // Output control cell (no. 107)
	localparam int unsigned SBST_CELL_EC  = 0;   // Echo clock cell
	localparam int unsigned SBST_CELL_ECI = 1;   // Inverted echo clock cell
	localparam int unsigned SBST_CELL_DQ  = 2;   // First data cell
	localparam int unsigned SBST_SYNC_N   = 3;   // Synchroniser depth

	// ------------------------------------------------------------
	// Pin modes, passed from the test clock to the system clock
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SBST_M_NORMAL = 2'h0, // Memory drives the pins
		SBST_M_EXT    = 2'h1, // Update register drives the pins
		SBST_M_HIZ    = 2'h3  // All outputs floated
	} sbst_mode_t;

	// ------------------------------------------------------------
	// Test controller states, standard codes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		SBST_TLR = 4'hf, SBST_RTI = 4'hc, SBST_SELDR = 4'h7, SBST_CAPDR = 4'h6,
		SBST_SHDR = 4'h2, SBST_EX1DR = 4'h1, SBST_PSDR = 4'h3, SBST_EX2DR = 4'h0,
		SBST_UPDR = 4'h5, SBST_SELIR = 4'h4, SBST_CAPIR = 4'he, SBST_SHIR = 4'ha,
		SBST_EX1IR = 4'h9, SBST_PSIR = 4'hb, SBST_EX2IR = 4'h8, SBST_UPIR = 4'hd
	} sbst_tap_t;
endpackage : sbst_pkg

// ### rtl/sbst_tap.sv
/*
 Boundary-scan test port of a DDR SRAM, with its update FIFO and pin drivers.
 Assumes an outside test controller on tck_i/tms_i/tdi_i and memory signals
 on clk_i; pads are sampled levels from the pin ring.
*/
// Functional notes
// R1 - IDCODE captures fixed value, shifts between TDI/TDO
// R2 - Instruction resets to IDCODE in test-logic-reset
// R3 - BYPASS puts bypass bit in shift-DR path
// R4 - SAMPLE captures inputs and pins, then shifts
// R5 - SAMPLE-Z floats data pins, shifts boundary register
// R6 - Decode 000,001,010,100,111 as listed instructions
// R7 - Controller never loads codes 011,101,110
// R8 - Control cell updates only at Update-DR, EXTEST/SAMPLE
// R9 - EXTEST drives update data; control gates data pins
// R10 - IDCODE, SAMPLE, BYPASS pins carry memory output
// R11 - SAMPLE-Z floats echo clocks and data pins
// R12 - EXTEST/SAMPLE-Z output cells capture pad levels
// R13 - SAMPLE captures internal output; idle data uses pads
// R14 - Controller holds inputs stable around sample capture
// R15 - Memory clocks may run except during capture; the bench keeps clk_i running through capture too
// R16 - EXTEST drives preloaded data from update-IR
// R17 - Sixteen-state controller, TMS rising, TDO falling
// R18 - Bypass bit captures zero
`timescale 1ns/1ns

// ------------------------------------------------------------
// Synchronous FIFO between the handshake and the pin driver
// ------------------------------------------------------------
module sbst_fifo #(
	parameter int unsigned W     = 8,
	parameter int unsigned DEPTH = 32
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	// Fill side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// Drain side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic      [W-1:0] out_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [W-1:0]  mem_q [DEPTH];   // Storage
	logic [AW-1:0] wp_q, wp_d;      // Write pointer
	logic [AW-1:0] rp_q, rp_d;      // Read pointer
	logic [AW:0]   cnt_q, cnt_d;    // Fill level
	logic          push, pop;       // Accepted transfers

	assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o  = mem_q[rp_q];

	// Pointer and level arithmetic
	always_comb begin
		push  = in_valid_i && in_ready_o;
		pop   = out_valid_o && out_ready_i;
		wp_d  = push ? AW'(wp_q + 1'b1) : wp_q;
		rp_d  = pop ? AW'(rp_q + 1'b1) : rp_q;
		cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	// Register pointers; storage has no reset
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wp_q] <= in_data_i;
		end
		if (reset_i) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end
endmodule : sbst_fifo

// ------------------------------------------------------------
// Test port top
// ------------------------------------------------------------
module sbst_tap import sbst_pkg::*; #(
	parameter int unsigned            DQ_W       = 18,
	parameter int unsigned            MIN_W      = 36,
	parameter int unsigned            FIFO_DEPTH = 32,
	parameter logic [SBST_ID_W-1:0]   ID_VALUE   = 32'h0a5a_0001 // Arbitrary value
) (
	// System clock and reset
	input  wire logic            clk_i,
	input  wire logic            reset_i,
	// Test port pins
	input  wire logic            tck_i,
	input  wire logic            tms_i,
	input  wire logic            tdi_i,
	output logic                 tdo_o,
	output logic                 tdo_oe_o,
	// Memory core side, system clock
	input  wire logic [MIN_W-1:0] mem_in_i,
	input  wire logic            sram_echo_i,
	input  wire logic            sram_echo_inv_i,
	input  wire logic [DQ_W-1:0] sram_dq_i,
	input  wire logic            sram_rd_i,
	// Pad levels seen at the pins
	input  wire logic            echo_clock_i,
	input  wire logic            echo_clock_inverted_i,
	input  wire logic [DQ_W-1:0] dq_i,
	// Pin drivers
	output logic                 echo_clock_o,
	output logic                 echo_clock_oe_o,
	output logic                 echo_clock_inverted_o,
	output logic                 echo_clock_inverted_oe_o,
	output logic      [DQ_W-1:0] dq_o,
	output logic                 dq_oe_o,
	// Drain stall for update words
	input  wire logic            upd_hold_i
);
	localparam int unsigned UW = DQ_W + 3;                 // {ctl, dq, inverted echo, echo}
	localparam int unsigned CW = MIN_W + 2*DQ_W + 5;       // Capture snapshot
	localparam int unsigned NC = SBST_CELL_DQ + DQ_W;      // Output cells

	// ------------------------------------------------------------
	// Test clock domain state
	// ------------------------------------------------------------
	sbst_tap_t             st_q, st_d;          // Controller state
	logic [2:0]            irs_q, irs_d;        // Instruction shift
	logic [2:0]            ir_q, ir_d;          // Active instruction
	logic                  byp_q, byp_d;        // Bypass bit
	logic [SBST_ID_W-1:0]  id_q, id_d;          // Identification shift
	logic [SBST_BSR_LEN-1:0] bsr_q, bsr_d;      // Boundary shift
	logic [UW-1:0]         upd_q, upd_d;        // Update register
	logic [UW-1:0]         hold_q, hold_d;      // Word held for crossing
	logic                  req_q, req_d;        // Request toggle
	logic                  pend_q, pend_d;      // Update waiting on busy
	sbst_mode_t            mode_q, mode_d;      // Pin mode
	logic                  tdo_d, toe_d;        // Falling-edge output
	logic [SBST_SYNC_N-1:0] trs_q;              // Reset into test clock
	logic                  trst_q;              // Agreed reset
	logic [SBST_SYNC_N-1:0] ack_s_q;            // Ack back from system side
	logic                  ack_t_q;             // Agreed ack
	logic                  ack_c_q, ack_c_d;    // Ack toggle, system side
	logic [CW-1:0]         cs1_q, cs2_q, cs3_q; // Snapshot synchroniser
	logic [CW-1:0]         cap_q;               // Agreed snapshot
	logic [SBST_BSR_LEN-1:0] cap_v;             // Boundary capture value
	logic                  samp, rd_t;          // Capture selectors

	// Snapshot fields
	logic                  p_ec, p_eci, s_ec, s_eci;
	logic [DQ_W-1:0]       p_dq, s_dq;
	logic [MIN_W-1:0]      m_in;
	assign {m_in, rd_t, s_dq, s_eci, s_ec, p_dq, p_eci, p_ec} = cap_q;

	// Next controller state
	function automatic sbst_tap_t tap_next(sbst_tap_t s, logic m);
		unique case (s)
			SBST_TLR:   return m ? SBST_TLR : SBST_RTI;
			SBST_RTI:   return m ? SBST_SELDR : SBST_RTI;
			SBST_SELDR: return m ? SBST_SELIR : SBST_CAPDR;
			SBST_CAPDR: return m ? SBST_EX1DR : SBST_SHDR;
			SBST_SHDR:  return m ? SBST_EX1DR : SBST_SHDR;
			SBST_EX1DR: return m ? SBST_UPDR : SBST_PSDR;
			SBST_PSDR:  return m ? SBST_EX2DR : SBST_PSDR;
			SBST_EX2DR: return m ? SBST_UPDR : SBST_SHDR;
			SBST_UPDR:  return m ? SBST_SELDR : SBST_RTI;
			SBST_SELIR: return m ? SBST_TLR : SBST_CAPIR;
			SBST_CAPIR: return m ? SBST_EX1IR : SBST_SHIR;
			SBST_SHIR:  return m ? SBST_EX1IR : SBST_SHIR;
			SBST_EX1IR: return m ? SBST_UPIR : SBST_PSIR;
			SBST_PSIR:  return m ? SBST_EX2IR : SBST_PSIR;
			SBST_EX2IR: return m ? SBST_UPIR : SBST_SHIR;
			SBST_UPIR:  return m ? SBST_SELDR : SBST_RTI;
		endcase
	endfunction : tap_next

	// Synchronisers into the test clock; pads may move mid-capture
	always_ff @(posedge tck_i) begin
		trs_q   <= {trs_q[SBST_SYNC_N-2:0], reset_i};
		ack_s_q <= {ack_s_q[SBST_SYNC_N-2:0], ack_c_q};
		cs1_q   <= {mem_in_i, sram_rd_i, sram_dq_i, sram_echo_inv_i, sram_echo_i,
		            dq_i, echo_clock_inverted_i, echo_clock_i};
		cs2_q   <= cs1_q;
		cs3_q   <= cs2_q;
		trst_q  <= (trs_q[1] == trs_q[2]) ? trs_q[2] : trst_q;
		ack_t_q <= (ack_s_q[1] == ack_s_q[2]) ? ack_s_q[2] : ack_t_q;
		cap_q   <= (cs2_q == cs3_q) ? cs3_q : cap_q;
	end

	// Boundary capture value per instruction
	always_comb begin
		samp  = (ir_q == SBST_I_SAMPLE);
		cap_v = '0;
		cap_v[SBST_CELL_EC]  = samp ? s_ec : p_ec;                  // R12 R13
		cap_v[SBST_CELL_ECI] = samp ? s_eci : p_eci;                // R12 R13
		cap_v[NC-1:SBST_CELL_DQ] = (samp && rd_t) ? s_dq : p_dq;    // R12 R13
		cap_v[NC+MIN_W-1:NC] = m_in;                                // R4
		cap_v[SBST_CTL_BIT]  = upd_q[UW-1];
	end

	// Controller, instruction and data registers
	always_comb begin
		st_d   = tap_next(st_q, tms_i);                             // R17
		irs_d  = irs_q;
		ir_d   = ir_q;
		byp_d  = byp_q;
		id_d   = id_q;
		bsr_d  = bsr_q;
		upd_d  = upd_q;
		unique case (st_q)
			SBST_TLR:   ir_d = SBST_I_IDCODE;                        // R2
			SBST_CAPIR: irs_d = SBST_IR_CAPTURE;
			SBST_SHIR:  irs_d = {tdi_i, irs_q[2:1]};
			SBST_UPIR:  ir_d = irs_q;                                // R6
			SBST_CAPDR: begin
				byp_d = 1'b0;                                        // R18
				id_d  = ID_VALUE;                                    // R1
				bsr_d = cap_v;                                       // R4
			end
			SBST_SHDR: begin
				byp_d = tdi_i;                                       // R3
				id_d  = {tdi_i, id_q[SBST_ID_W-1:1]};                // R1
				bsr_d = {tdi_i, bsr_q[SBST_BSR_LEN-1:1]};            // R4 R5
			end
			SBST_UPDR: begin
				// Only these two instructions touch the update register
				if (ir_q == SBST_I_EXTEST || ir_q == SBST_I_SAMPLE) begin
					upd_d = {bsr_q[SBST_CTL_BIT], bsr_q[NC-1:0]};    // R8
				end
			end
			default: ;
		endcase
		// Pin mode follows the active instruction
		unique case (ir_d)
			SBST_I_EXTEST: mode_d = SBST_M_EXT;                      // R9 R16
			SBST_I_SAMPZ:  mode_d = SBST_M_HIZ;                      // R5 R11
			default:       mode_d = SBST_M_NORMAL;                   // R10
		endcase
	end

	// Handshake launch; a second update while busy waits in pend
	always_comb begin
		pend_d = pend_q || (upd_d != upd_q);
		hold_d = hold_q;
		req_d  = req_q;
		if (pend_d && (req_q == ack_t_q)) begin
			hold_d = upd_d;
			req_d  = ~req_q;
			pend_d = 1'b0;
		end
	end

	// Serial output path; reserved codes behave as bypass
	always_comb begin
		tdo_d = 1'b0;
		toe_d = 1'b0;
		if (st_q == SBST_SHIR) begin
			tdo_d = irs_q[0];
			toe_d = 1'b1;
		end else if (st_q == SBST_SHDR) begin
			toe_d = 1'b1;
			unique case (ir_q)
				SBST_I_IDCODE: tdo_d = id_q[0];                      // R1
				SBST_I_EXTEST, SBST_I_SAMPZ, SBST_I_SAMPLE: tdo_d = bsr_q[0]; // R4 R5
				default:       tdo_d = byp_q;                        // R3
			endcase
		end
	end

	// Rising-edge registers of the test domain
	always_ff @(posedge tck_i) begin
		if (trst_q) begin
			st_q   <= SBST_TLR;
			irs_q  <= SBST_IR_CAPTURE;
			ir_q   <= SBST_I_IDCODE;                                 // R2
			byp_q  <= 1'b0;
			id_q   <= '0;
			bsr_q  <= '0;
			upd_q  <= '0;
			hold_q <= '0;
			req_q  <= 1'b0;
			pend_q <= 1'b0;
			mode_q <= SBST_M_NORMAL;
		end else begin
			st_q   <= st_d;
			irs_q  <= irs_d;
			ir_q   <= ir_d;
			byp_q  <= byp_d;
			id_q   <= id_d;
			bsr_q  <= bsr_d;
			upd_q  <= upd_d;
			hold_q <= hold_d;
			req_q  <= req_d;
			pend_q <= pend_d;
			mode_q <= mode_d;
		end
	end

	// Serial output changes on the falling edge
	always_ff @(negedge tck_i) begin
		if (trst_q) begin
			tdo_o    <= 1'b0;
			tdo_oe_o <= 1'b0;
		end else begin
			tdo_o    <= tdo_d;                                       // R17
			tdo_oe_o <= toe_d;
		end
	end

	// ------------------------------------------------------------
	// System clock domain
	// ------------------------------------------------------------
	logic [SBST_SYNC_N-1:0] rq_s_q;     // Request synchroniser
	logic                  rq_c_q;      // Agreed request
	logic [1:0]            md_s1_q, md_s2_q, md_s3_q;
	sbst_mode_t            mode_c_q;    // Agreed pin mode
	logic                  f_iv, f_ir, f_ov;
	logic [UW-1:0]         f_od;
	logic [UW-1:0]         pw_q, pw_d;  // Word on the pins under EXTEST

	// Synchronisers into the system clock
	always_ff @(posedge clk_i) begin
		rq_s_q  <= {rq_s_q[SBST_SYNC_N-2:0], req_q};
		md_s1_q <= mode_q;
		md_s2_q <= md_s1_q;
		md_s3_q <= md_s2_q;
		if (reset_i) begin
			rq_c_q   <= 1'b0;
			mode_c_q <= SBST_M_NORMAL;
		end else begin
			rq_c_q   <= (rq_s_q[1] == rq_s_q[2]) ? rq_s_q[2] : rq_c_q;
			mode_c_q <= (md_s2_q == md_s3_q) ? sbst_mode_t'(md_s3_q) : mode_c_q;
		end
	end

	// Held word is stable while the request is open; ack only when FIFO takes it
	always_comb begin
		f_iv    = (rq_c_q != ack_c_q);
		ack_c_d = (f_iv && f_ir) ? rq_c_q : ack_c_q;
		pw_d    = (f_ov && !upd_hold_i) ? f_od : pw_q;
	end

	sbst_fifo #(.W(UW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.in_valid_i  (f_iv),
		.in_ready_o  (f_ir),
		.in_data_i   (hold_q),
		.out_valid_o (f_ov),
		.out_ready_i (!upd_hold_i),
		.out_data_o  (f_od)
	);

	// Pin drivers, all registered
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ack_c_q                  <= 1'b0;
			pw_q                     <= '0;
			echo_clock_o             <= 1'b0;
			echo_clock_oe_o          <= 1'b0;
			echo_clock_inverted_o    <= 1'b0;
			echo_clock_inverted_oe_o <= 1'b0;
			dq_o                     <= '0;
			dq_oe_o                  <= 1'b0;
		end else begin
			ack_c_q <= ack_c_d;
			pw_q    <= pw_d;
			unique case (mode_c_q)
				SBST_M_EXT: begin                                    // R9 R16
					echo_clock_o             <= pw_q[SBST_CELL_EC];
					echo_clock_oe_o          <= 1'b1;
					echo_clock_inverted_o    <= pw_q[SBST_CELL_ECI];
					echo_clock_inverted_oe_o <= 1'b1;
					dq_o                     <= pw_q[NC-1:SBST_CELL_DQ];
					dq_oe_o                  <= pw_q[UW-1];
				end
				SBST_M_HIZ: begin                                    // R5 R11
					echo_clock_oe_o          <= 1'b0;
					echo_clock_inverted_oe_o <= 1'b0;
					dq_oe_o                  <= 1'b0;
				end
				default: begin                                       // R10
					echo_clock_o             <= sram_echo_i;
					echo_clock_oe_o          <= 1'b1;
					echo_clock_inverted_o    <= sram_echo_inv_i;
					echo_clock_inverted_oe_o <= 1'b1;
					dq_o                     <= sram_dq_i;
					dq_oe_o                  <= sram_rd_i;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_tms_hi;
		tms_i [*5];
	endsequence
	sequence s_cap_dr(logic [2:0] ins);
		st_q == SBST_CAPDR && ir_q == ins;
	endsequence

	a_tms_reset: assert property (@(posedge tck_i) disable iff (trst_q) // R17
		s_tms_hi |=> st_q == SBST_TLR) else $error("five TMS highs missed reset");
	a_tlr_idcode: assert property (@(posedge tck_i) disable iff (trst_q) // R2
		st_q == SBST_TLR |=> ir_q == SBST_I_IDCODE) else $error("IR not IDCODE");
	a_id_capture: assert property (@(posedge tck_i) disable iff (trst_q) // R1
		s_cap_dr(SBST_I_IDCODE) |=> id_q == ID_VALUE) else $error("ID not captured");
	a_bypass_zero: assert property (@(posedge tck_i) disable iff (trst_q) // R18
		s_cap_dr(SBST_I_BYPASS) |=> !byp_q) else $error("bypass captured one");
	a_bypass_path: assert property (@(posedge tck_i) disable iff (trst_q) // R3
		st_q == SBST_SHDR && ir_q == SBST_I_BYPASS |-> tdo_o == byp_q && tdo_oe_o)
		else $error("bypass not on serial path");
	a_ctl_update: assert property (@(posedge tck_i) disable iff (trst_q) // R8
		$changed(upd_q[UW-1]) |-> $past(st_q) == SBST_UPDR
		&& ($past(ir_q) == SBST_I_EXTEST || $past(ir_q) == SBST_I_SAMPLE))
		else $error("control cell changed outside update");
	a_decode_hiz: assert property (@(posedge tck_i) disable iff (trst_q) // R6
		ir_q == SBST_I_SAMPZ && st_q != SBST_TLR && st_q != SBST_UPIR
		|=> mode_q == SBST_M_HIZ) else $error("SAMPLE-Z mode wrong");
	a_hiz_pins: assert property (@(posedge clk_i) disable iff (reset_i) // R11
		mode_c_q == SBST_M_HIZ |=> !dq_oe_o && !echo_clock_oe_o
		&& !echo_clock_inverted_oe_o) else $error("pin driven in SAMPLE-Z");
	a_normal_pins: assert property (@(posedge clk_i) disable iff (reset_i) // R10
		mode_c_q == SBST_M_NORMAL |=> dq_o == $past(sram_dq_i)
		&& dq_oe_o == $past(sram_rd_i)) else $error("pins not from memory");
	a_ext_ctl: assert property (@(posedge clk_i) disable iff (reset_i) // R9
		mode_c_q == SBST_M_EXT |=> dq_oe_o == $past(pw_q[UW-1]) && echo_clock_oe_o)
		else $error("EXTEST drive wrong");
endmodule : sbst_tap

// ### verification/sbst_ctl_model.sv
/*
 Behavioural test controller standing on the far side of the test port.
 Assumes the port samples mode select on rising and shifts out on falling edges.
*/
`timescale 1ns/1ns
module sbst_ctl_model (
	// Test port lines
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	input  wire logic tdo_i
);
	// ------------------------------------------------------------
	// Idle: clock stands still, lines rest at pull-up level
	// ------------------------------------------------------------
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
	end

	// One 15 ns test clock; serial out is read at the rising edge
	task automatic step(input logic ms, input logic di, output logic do_v);
		tms_o = ms;
		tdi_o = di;
		#7 tck_o = 1'b1;
		do_v = tdo_i;
		#8 tck_o = 1'b0;
	endtask : step

	// Repeated clocks with a fixed mode select
	task automatic run(input logic ms, input int n);
		logic d;
		for (int i = 0; i < n; i++) step(ms, 1'b1, d);
	endtask : run

	// Idle to capture, shift n bits, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [127:0] din,
		output logic [127:0] dout);
		logic d;
		dout = '0;
		step(1'b1, 1'b1, d);
		if (ir) step(1'b1, 1'b1, d);
		step(1'b0, 1'b1, d); // Into capture
		step(1'b0, 1'b1, d); // Into shift
		for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
		step(1'b1, 1'b1, d); // Into update
		step(1'b0, 1'b1, d);
		run(1'b0, 12); // Idle clocks; pins can still lag this update at the next capture
	endtask : scan

	// Only four of the five defined codes are ever passed in; IDCODE never is
	task automatic load(input logic [2:0] code, output logic [2:0] cap);
		logic [127:0] o;
		scan(1'b1, 3, {125'h0, code}, o);
		cap = o[2:0];
	endtask : load
endmodule : sbst_ctl_model

// ### verification/testbench.sv
/*
 Self-checking bench for the boundary-scan test port.
 Assumes sbst_ctl_model as the test controller and the pads modelled here.
*/
`timescale 1ns/1ns
module testbench import sbst_pkg::*;;
	// ------------------------------------------------------------
	// Stimulus values and signals
	// ------------------------------------------------------------
	localparam logic [31:0] TB_ID  = 32'h1234_abcd; // Arbitrary value
	localparam logic [17:0] PRE_DQ = 18'h3_0c0f;
	localparam logic [17:0] DQ2    = 18'h0_f0f3;
	localparam logic [35:0] MEM_V  = 36'h9_8765_4321;
	localparam logic [17:0] SRAM_V = 18'h1_2345;
	localparam logic [17:0] PAD_V  = 18'h2_a5a5;
	logic         clk_i = 1'b0, reset_i = 1'b1, tck, tms, tdi, tdo_o, tdo_oe_o;
	logic [35:0]  mem_in_i = MEM_V;
	logic         sram_echo_i = 1'b1, sram_echo_inv_i = 1'b0, sram_rd_i = 1'b1, upd_hold_i = 1'b0;
	logic [17:0]  sram_dq_i = SRAM_V, pad_dq = PAD_V, dq_o;
	// Board echo levels oppose the last EXTEST drive, so a float shows in echo capture
	logic         pad_ec = 1'b1, pad_eci = 1'b0, dq_oe_o;
	logic         echo_clock_o, echo_clock_oe_o, echo_clock_inverted_o, echo_clock_inverted_oe_o;
	logic [127:0] o;
	logic [2:0]   cap;
	int           err_count = 0, checked = 0;
	// Pad levels: the port's own drive wins, else the board's value
	wire          echo_clock_i = echo_clock_oe_o ? echo_clock_o : pad_ec;
	wire          echo_clock_inverted_i = echo_clock_inverted_oe_o ? echo_clock_inverted_o : pad_eci;
	wire   [17:0] dq_i = dq_oe_o ? dq_o : pad_dq;
	wire   [22:0] pins = {echo_clock_oe_o, echo_clock_o, echo_clock_inverted_oe_o,
		echo_clock_inverted_o, dq_oe_o, dq_o};

	// System clock keeps running through every test operation
	always #20 clk_i = ~clk_i;

	sbst_ctl_model sbst_ctl_model_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_o));
	sbst_tap #(.ID_VALUE(TB_ID)) sbst_tap_inst (.clk_i, .reset_i, .tck_i(tck), .tms_i(tms),
		.tdi_i(tdi), .tdo_o, .tdo_oe_o, .mem_in_i, .sram_echo_i, .sram_echo_inv_i, .sram_dq_i,
		.sram_rd_i, .echo_clock_i, .echo_clock_inverted_i, .dq_i, .echo_clock_o,
		.echo_clock_oe_o, .echo_clock_inverted_o, .echo_clock_inverted_oe_o, .dq_o, .dq_oe_o,
		.upd_hold_i);

	// ------------------------------------------------------------
	// Shared checking tasks
	// ------------------------------------------------------------
	task automatic cmp(input string nm, input logic [127:0] e, input logic [127:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp

	// Bounded wait for the pins to reach a value; a hang ends the run
	task automatic wait_pins(input string nm, input logic [22:0] e, input logic [22:0] m);
		int i;
		for (i = 0; i < 60 && (pins & m) !== (e & m); i++) begin
			@(posedge clk_i);
			#1;
		end
		cmp(nm, {105'h0, e & m}, {105'h0, pins & m});
		if (i == 60) close_out();
	endtask : wait_pins

	task automatic close_out;
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : close_out

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_idcode;
		sbst_ctl_model_inst.scan(1'b0, 32, 128'h0, o);
		cmp("idcode after reset", {96'h0, TB_ID}, o);
		cmp("tdo idle", 128'h0, {127'h0, tdo_oe_o});
		$display("idcode done");
	endtask : t_idcode

	task automatic t_bypass;
		sbst_ctl_model_inst.load(SBST_I_BYPASS, cap);
		cmp("ir capture", {125'h0, SBST_IR_CAPTURE}, {125'h0, cap});
		sbst_ctl_model_inst.scan(1'b0, 4, 128'h1, o);
		cmp("bypass path", 128'h2, o);
		@(posedge clk_i);
		#1 sram_rd_i = 1'b0;
		wait_pins("bypass pins", {3'h7, 1'b0, 1'b0, SRAM_V}, '1);
		$display("bypass done");
	endtask : t_bypass

	task automatic t_tlr;
		sbst_ctl_model_inst.run(1'b1, 5);
		sbst_ctl_model_inst.run(1'b0, 1);
		sbst_ctl_model_inst.scan(1'b0, 32, 128'h0, o);
		cmp("idcode after tlr", {96'h0, TB_ID}, o);
		$display("tlr done");
	endtask : t_tlr

	task automatic t_sample;
		@(posedge clk_i);
		#1 sram_rd_i = 1'b1;
		sbst_ctl_model_inst.load(SBST_I_SAMPLE, cap);
		sbst_ctl_model_inst.scan(1'b0, 107, {21'h0, 1'b1, 86'h0, PRE_DQ, 2'h1}, o);
		cmp("sample read", {72'h0, MEM_V, SRAM_V, 2'h1}, {72'h0, o[55:0]});
		wait_pins("sample pins", {3'h7, 1'b0, 1'b1, SRAM_V}, '1);
		@(posedge clk_i);
		#1 sram_rd_i = 1'b0;
		sbst_ctl_model_inst.run(1'b0, 6);
		sbst_ctl_model_inst.scan(1'b0, 107, {21'h0, 1'b1, 86'h0, PRE_DQ, 2'h1}, o);
		cmp("sample idle", {108'h0, PAD_V, 2'h1}, {108'h0, o[19:0]});
		$display("sample done");
	endtask : t_sample

	task automatic t_extest;
		sbst_ctl_model_inst.load(SBST_I_EXTEST, cap);
		wait_pins("extest preload", {3'h7, 1'b0, 1'b1, PRE_DQ}, '1);
		upd_hold_i = 1'b1;
		// Capture sees pads through the test-clock synchroniser: clock it past the new pins
		sbst_ctl_model_inst.run(1'b0, 6);
		sbst_ctl_model_inst.scan(1'b0, 107, {22'h0, 86'h0, DQ2, 2'h2}, o);
		cmp("extest capture", {108'h0, PRE_DQ, 2'h1}, {108'h0, o[19:0]});
		repeat (30) @(posedge clk_i);
		#1 cmp("held word", {105'h0, 3'h7, 1'b0, 1'b1, PRE_DQ}, {105'h0, pins});
		upd_hold_i = 1'b0;
		wait_pins("extest ctl low", {3'h5, 1'b1, 1'b0, DQ2}, '1);
		$display("extest done");
	endtask : t_extest

	task automatic t_sampz;
		sbst_ctl_model_inst.load(SBST_I_SAMPZ, cap);
		wait_pins("sampz float", 23'h0, {1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 18'h0});
		sbst_ctl_model_inst.run(1'b0, 6);
		sbst_ctl_model_inst.scan(1'b0, 107, 128'h0, o);
		cmp("sampz capture", {108'h0, PAD_V, 2'h1}, {108'h0, o[19:0]});
		$display("sampz done");
	endtask : t_sampz

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		sbst_ctl_model_inst.run(1'b1, 12);
		@(posedge clk_i);
		#1 reset_i = 1'b0;
		sbst_ctl_model_inst.run(1'b1, 8);
		sbst_ctl_model_inst.run(1'b0, 1);
		t_idcode();
		t_bypass();
		t_tlr();
		t_sample();
		t_extest();
		t_sampz();
		close_out();
	end
endmodule : testbench
